// *** src/fbsc_consts.svh ***
`ifndef FBSC_CONSTS_SVH
`define FBSC_CONSTS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FBSC_ADDR_W    18
`define FBSC_DATA_W    16
`define FBSC_PAR_W     2
`define FBSC_WORD_W    18
`define FBSC_LANES     2
`define FBSC_LANE_W    8
`define FBSC_DEPTH     262144
`define FBSC_ENT_W     38

// ----------------------------------------------------------------
// Burst counter
// ----------------------------------------------------------------
`define FBSC_BEAT_W    2
`define FBSC_BEAT_ONE  2'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FBSC_RST_ADDR  18'h0_0000
`define FBSC_RST_WORD  18'h0_0000
`define FBSC_RST_BEAT  2'h0
`define FBSC_RST_LANES 2'h3

`endif

// *** src/fbsc_pkg.sv ***
package fbsc_pkg;

   // -------------------------------------------------------------
   // Operation held for the rest of a burst
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      op_idle,
      op_read,
      op_write
   } fbsc_op_type;

endpackage : fbsc_pkg

// *** src/fbsc_pair_buf.sv ***
`include "fbsc_consts.svh"

module fbsc_pair_buf
   import fbsc_pkg::*;
#(
   parameter int WIDTH = `FBSC_ENT_W
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // Status
   output logic                  full
);

   // ----------------------------------------------------------------
   // Two slots, slot 0 is the head
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] ent_q [2];
   logic [WIDTH-1:0] ent_d [2];
   logic [1:0]       vld_q;
   logic [1:0]       vld_d;
   logic             push;
   logic             pop;

   assign in_ready  = ~vld_q[1];
   assign full      = vld_q[1];
   assign out_valid = vld_q[0];
   assign out_data  = ent_q[0];
   assign push      = in_valid & ~vld_q[1];
   assign pop       = vld_q[0] & out_ready;

   // Shift on pop, then fill the first free slot
   always_comb begin
      ent_d = ent_q;
      vld_d = vld_q;
      if (pop) begin
         ent_d[0] = ent_q[1];
         vld_d    = {1'b0, vld_q[1]};
      end
      if (push) begin
         if (!vld_d[0]) begin
            ent_d[0] = in_data;
            vld_d[0] = 1'b1;
         end else begin
            ent_d[1] = in_data;
            vld_d[1] = 1'b1;
         end
      end
   end

   // Data slots need no reset; valid flags do
   always_ff @(posedge sys_clk) begin
      ent_q <= ent_d;
      if (!rst_n) begin
         vld_q <= 2'h0;
      end else begin
         vld_q <= vld_d;
      end
   end

endmodule // fbsc_pair_buf

// *** src/fbsc_ctrl.sv ***
// Contract
// - Qualify high: edge ignored, every internal state held; code still drains the write buffer and steps the sleep synchroniser.
// - All synchronous inputs captured on rising clock edge.
// - Read starts: qualified, all selects active, strobe high, load; address latched.
// - Read data driven after first clock only while output enable low; code registers enable at qualified edges only.
// - Deselect at a clock rise turns data and parity drivers off.
// - Burst counter gives up to four accesses; load only when load/advance low.
// - Strap low selects linear order, high or floating interleaved.
// - Counter touches only two low address bits and wraps in group.
// - Advance high steps counter regardless of selects and strobe.
// - Direction latched at burst load, kept for remaining beats.
// - Write starts: qualified, selects active, strobe low; drivers released.
// - Write data captured on following edge; new command allowed there.
// - Only lanes with active-low select are written, with parity bit.
// - Drivers off during write data phase whatever output enable is.
// - Write continuation beats ignore selects and strobe, only advance.
// - Sleep input: low-power state keeps contents; enter and exit two clocks.
// - Access pending at sleep entry may be lost.
// - Linear order: low bits increment modulo four from start.
// - Interleaved order: low bits equal start XOR beat count.
// - First clock out of deselect keeps drivers off; code turns them on at once for a read there if enable is low.
// - After reset: deselected, drivers off regardless of output enable.
`include "fbsc_consts.svh"

module fbsc_ctrl
   import fbsc_pkg::*;
(
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // Command inputs
   input  wire logic                      clock_qualify_n,
   input  wire logic                      chip_select_1_n,
   input  wire logic                      chip_select_2,
   input  wire logic                      chip_select_3_n,
   input  wire logic                      write_strobe_n,
   input  wire logic                      advance_or_load,
   input  wire logic [`FBSC_LANES-1:0]    byte_lane_write_n,
   input  wire logic [`FBSC_ADDR_W-1:0]   address,
   input  wire logic                      output_enable_n,
   input  wire logic                      sleep_request,
   input  wire logic                      burst_order,
   // Data pins
   input  wire logic [`FBSC_DATA_W-1:0]   data_io_i,
   output logic [`FBSC_DATA_W-1:0]        data_io_o,
   output logic                           data_io_oe_n,
   input  wire logic [`FBSC_PAR_W-1:0]    parity_io_i,
   output logic [`FBSC_PAR_W-1:0]         parity_io_o,
   output logic                           parity_io_oe_n,
   // Status
   output logic                           write_stall,
   output logic                           sleep_active
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Lane merge, shared by write-back and read forwarding
   function automatic logic [`FBSC_WORD_W-1:0] lane_merge(
      input logic [`FBSC_WORD_W-1:0] old_w,
      input logic [`FBSC_WORD_W-1:0] new_w,
      input logic [`FBSC_LANES-1:0]  lanes_n);
      logic [`FBSC_WORD_W-1:0] r;
      r = old_w;
      for (int k = 0; k < `FBSC_LANES; k++) begin
         if (!lanes_n[k]) begin
            r[k*`FBSC_LANE_W +: `FBSC_LANE_W] = new_w[k*`FBSC_LANE_W +: `FBSC_LANE_W];
            r[`FBSC_DATA_W+k] = new_w[`FBSC_DATA_W+k];
         end
      end
      return r;
   endfunction

   // Low address bits for a beat; only bits 1:0 ever move
   function automatic logic [1:0] burst_lo(
      input logic [1:0] start,
      input logic [1:0] beat,
      input logic       ilv);
      return ilv ? (start ^ beat) : 2'(start + beat);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [`FBSC_WORD_W-1:0] mem [`FBSC_DEPTH];
   fbsc_op_type             op_q, op_d;
   logic [`FBSC_ADDR_W-1:0] base_q, base_d;
   logic [`FBSC_BEAT_W-1:0] beat_q, beat_d;
   logic                    order_q, order_d;
   logic                    cur_wr_q, cur_wr_d;
   logic [`FBSC_ADDR_W-1:0] wr_addr_q, wr_addr_d;
   logic [`FBSC_LANES-1:0]  wr_lanes_q, wr_lanes_d;
   logic [`FBSC_WORD_W-1:0] rd_word_q, rd_word_d;
   logic                    drive_n_q, drive_n_d;
   logic                    sleep_meta_q, sleep_meta_d;
   logic                    sleep_q, sleep_d;
   logic                    sel;
   logic                    go;
   logic                    rd_cyc;
   logic                    wr_cyc;
   logic [`FBSC_ADDR_W-1:0] eff_addr;
   logic [`FBSC_WORD_W-1:0] in_word;
   logic [`FBSC_ENT_W-1:0]  push_ent;
   logic [`FBSC_ENT_W-1:0]  head_ent;
   logic                    push_ready;
   logic                    head_valid;
   logic                    buf_full;
   logic                    mem_we;
   logic [`FBSC_ADDR_W-1:0] head_addr;
   logic [`FBSC_LANES-1:0]  head_lanes;
   logic [`FBSC_WORD_W-1:0] head_word;

   // ----------------------------------------------------------------
   // Sleep synchroniser
   // ----------------------------------------------------------------
   // Two stages: the asynchronous pin settles, and entry and exit
   // each cost exactly two edges
   always_comb begin
      sleep_meta_d = sleep_request;
      sleep_d      = sleep_meta_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sleep_meta_q <= 1'b0;
         sleep_q      <= 1'b0;
      end else begin
         sleep_meta_q <= sleep_meta_d;
         sleep_q      <= sleep_d;
      end
   end

   // ----------------------------------------------------------------
   // Write path buffer
   // ----------------------------------------------------------------
   // Data phase word as it arrives on the pins
   assign in_word  = {parity_io_i, data_io_i};
   assign push_ent = {wr_addr_q, wr_lanes_q, in_word};
   assign {head_addr, head_lanes, head_word} = head_ent;
   // Array writes pause in sleep so the buffer can back up
   assign mem_we   = head_valid & ~sleep_q;

   fbsc_pair_buf #(
      .WIDTH     (`FBSC_ENT_W)
   ) u_wbuf (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (go & cur_wr_q),
      .in_ready  (push_ready),
      .in_data   (push_ent),
      .out_valid (head_valid),
      .out_ready (~sleep_q),
      .out_data  (head_ent),
      .full      (buf_full)
   );

   // Array keeps no reset so contents survive sleep
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[head_addr] <= lane_merge(mem[head_addr], head_word, head_lanes);
      end
   end

   // ----------------------------------------------------------------
   // Command decode and burst control
   // ----------------------------------------------------------------
   assign sel = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
   // A full buffer with write data pending stalls the edge exactly as qualify high does
   assign go  = ~clock_qualify_n & ~sleep_q & (~cur_wr_q | push_ready);

   // Next burst state; the read word is forwarded past pending writes
   always_comb begin
      op_d       = op_q;
      base_d     = base_q;
      beat_d     = beat_q;
      order_d    = order_q;
      cur_wr_d   = cur_wr_q;
      wr_addr_d  = wr_addr_q;
      wr_lanes_d = wr_lanes_q;
      rd_word_d  = rd_word_q;
      drive_n_d  = drive_n_q;
      eff_addr   = base_q;
      rd_cyc     = 1'b0;
      wr_cyc     = 1'b0;
      if (sleep_q) begin
         // Pending access dropped on sleep entry
         op_d      = op_idle;
         cur_wr_d  = 1'b0;
         drive_n_d = 1'b1;
      end else if (go) begin
         if (!advance_or_load) begin
            // Fresh address only on load
            base_d   = address;
            eff_addr = address;
            beat_d   = `FBSC_RST_BEAT;
            order_d  = burst_order;
            if (!sel) begin
               op_d = op_idle;
            end else if (write_strobe_n) begin
               op_d = op_read;
            end else begin
               op_d = op_write;
            end
         end else if (op_q != op_idle) begin
            // Selects and strobe are not looked at here
            beat_d   = beat_q + `FBSC_BEAT_ONE;
            eff_addr = {base_q[`FBSC_ADDR_W-1:2], burst_lo(base_q[1:0], beat_d, order_q)};
         end
         rd_cyc     = (op_d == op_read);
         wr_cyc     = (op_d == op_write);
         cur_wr_d   = wr_cyc;
         wr_addr_d  = eff_addr;
         wr_lanes_d = byte_lane_write_n;
         // Drive only for a read whose enable is low; writes and
         // deselects stay off, and a read just after a deselect drives from its own edge
         drive_n_d  = ~(rd_cyc & ~output_enable_n);
         if (rd_cyc) begin
            rd_word_d = mem[eff_addr];
            if (head_valid && head_addr == eff_addr) begin
               rd_word_d = lane_merge(rd_word_d, head_word, head_lanes);
            end
            if (cur_wr_q && wr_addr_q == eff_addr) begin
               rd_word_d = lane_merge(rd_word_d, in_word, wr_lanes_q);
            end
         end
      end
   end

   // Registers of the burst and output stage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         op_q       <= op_idle;
         base_q     <= `FBSC_RST_ADDR;
         beat_q     <= `FBSC_RST_BEAT;
         order_q    <= 1'b1;
         cur_wr_q   <= 1'b0;
         wr_addr_q  <= `FBSC_RST_ADDR;
         wr_lanes_q <= `FBSC_RST_LANES;
         rd_word_q  <= `FBSC_RST_WORD;
         drive_n_q  <= 1'b1;
      end else begin
         op_q       <= op_d;
         base_q     <= base_d;
         beat_q     <= beat_d;
         order_q    <= order_d;
         cur_wr_q   <= cur_wr_d;
         wr_addr_q  <= wr_addr_d;
         wr_lanes_q <= wr_lanes_d;
         rd_word_q  <= rd_word_d;
         drive_n_q  <= drive_n_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign data_io_o      = rd_word_q[`FBSC_DATA_W-1:0];
   assign parity_io_o    = rd_word_q[`FBSC_WORD_W-1:`FBSC_DATA_W];
   assign data_io_oe_n   = drive_n_q;
   assign parity_io_oe_n = drive_n_q;
   assign write_stall    = buf_full;
   assign sleep_active   = sleep_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [1:0] exp_lo;
   logic       rd_drive;

   assign exp_lo   = order_q ? (base_q[1:0] ^ 2'(beat_q + 2'h1))
                             : 2'(base_q[1:0] + beat_q + 2'h1);
   assign rd_drive = go & rd_cyc & ~output_enable_n;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_stall_hold: assert property (
      clock_qualify_n && !sleep_q |=> $stable(op_q) && $stable(base_q) && $stable(beat_q))
      else $error("state moved on an unqualified edge");

   chk_read_start: assert property (
      go && sel && write_strobe_n && !advance_or_load
      |=> op_q == op_read && base_q == $past(address))
      else $error("read start not latched");

   // Drivers may also stand through an ignored edge that followed a driving read
   chk_read_drive: assert property (
      !data_io_oe_n |-> $past(rd_drive) || $past(!go && !sleep_q && !data_io_oe_n))
      else $error("drivers on without a read and enable");

   chk_deselect_off: assert property (
      go && !advance_or_load && !sel |=> data_io_oe_n && op_q == op_idle)
      else $error("drivers on after deselect");

   chk_beat_step: assert property (
      go && advance_or_load && op_q != op_idle |=> beat_q == 2'($past(beat_q) + 2'h1))
      else $error("burst counter did not step");

   chk_order_seq: assert property (
      go && advance_or_load && op_q != op_idle
      |=> wr_addr_q[1:0] == $past(exp_lo) && wr_addr_q[17:2] == $past(base_q[17:2]))
      else $error("burst address out of sequence");

   chk_dir_kept: assert property (
      go && advance_or_load |=> op_q == $past(op_q))
      else $error("direction changed inside a burst");

   chk_write_off: assert property (
      cur_wr_q |-> data_io_oe_n)
      else $error("drivers on during write data phase");

   chk_write_take: assert property (
      go && cur_wr_q && !head_valid |=> head_valid && head_word == $past(in_word))
      else $error("write data not captured");

   chk_sleep_enter: assert property (
      sleep_request [*2] |=> sleep_q ##0 data_io_oe_n)
      else $error("sleep not entered in two clocks");

   chk_reset_off: assert property (disable iff (1'b0)
      !rst_n |=> data_io_oe_n && op_q == op_idle)
      else $error("not deselected after reset");

   cov_read_burst: cover property (
      go && !advance_or_load && sel && write_strobe_n ##1 (go && advance_or_load) [*3]);
   cov_write_read: cover property (
      go && wr_cyc ##1 go && rd_cyc && cur_wr_q && wr_addr_q == eff_addr);
   cov_sleep_cycle: cover property (sleep_q ##1 !sleep_q);
   cov_buf_full: cover property (buf_full);

endmodule // fbsc_ctrl

// *** verif/fbsc_far_model.sv ***
`include "fbsc_consts.svh"

module fbsc_far_model (
   // Clock
   input  wire logic                    sys_clk,
   // Controller side of the shared pins
   input  wire logic                    ctl_drive,
   input  wire logic [`FBSC_WORD_W-1:0] ctl_word,
   // Device side of the shared pins
   input  wire logic                    dev_oe_n,
   input  wire logic [`FBSC_WORD_W-1:0] dev_word,
   // Resolved pin value and contention flag
   output logic [`FBSC_WORD_W-1:0]      pin_word,
   output logic                         clash
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [`FBSC_WORD_W-1:0] float_q;

   // Undriven pins toggle every cycle, so stale data never passes for valid
   initial float_q = 18'h2_a5c3;
   always @(posedge sys_clk) float_q <= ~float_q;

   // Write data only while the bench asks for it, never against the device
   assign pin_word = !dev_oe_n ? dev_word : (ctl_drive ? ctl_word : float_q);
   assign clash    = ctl_drive && !dev_oe_n;
endmodule // fbsc_far_model

// *** verif/fbsc_ctrl_tb.sv ***
`include "fbsc_consts.svh"

module fbsc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals and reference state
   // ------------------------------------------------------------
   localparam int WW = `FBSC_WORD_W;
   localparam int AW = `FBSC_ADDR_W;
   localparam int OP_DES = 0, OP_RD = 1, OP_WR = 2, OP_ADV = 3, OP_HOLD = 4, OP_SLP = 5;
   logic          sys_clk = 1'b0;
   logic          rst_n, clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n;
   logic          write_strobe_n, advance_or_load, output_enable_n, sleep_request;
   logic          burst_order, data_io_oe_n, parity_io_oe_n, write_stall, sleep_active;
   logic          ctl_drive, clash, b_act, b_wr, b_ilv, pend, exp_oe, ord;
   logic [1:0]    byte_lane_write_n, b_beat, p_lanes;
   logic [AW-1:0] address, b_start, p_addr, cur, gbase;
   logic [15:0]   data_io_o;
   logic [1:0]    parity_io_o;
   logic [WW-1:0] ctl_word, pin_word, exp_word;
   logic [WW-1:0] mem [int];
   integer        seed = 32'hb0bb;
   int            error_cnt = 0;
   int            comparisons = 0;
   int            op;

   always #10 sys_clk = ~sys_clk;

   fbsc_ctrl i_dut (
      .sys_clk           (sys_clk),
      .rst_n             (rst_n),
      .clock_qualify_n   (clock_qualify_n),
      .chip_select_1_n   (chip_select_1_n),
      .chip_select_2     (chip_select_2),
      .chip_select_3_n   (chip_select_3_n),
      .write_strobe_n    (write_strobe_n),
      .advance_or_load   (advance_or_load),
      .byte_lane_write_n (byte_lane_write_n),
      .address           (address),
      .output_enable_n   (output_enable_n),
      .sleep_request     (sleep_request),
      .burst_order       (burst_order),
      .data_io_i         (pin_word[15:0]),
      .data_io_o         (data_io_o),
      .data_io_oe_n      (data_io_oe_n),
      .parity_io_i       (pin_word[17:16]),
      .parity_io_o       (parity_io_o),
      .parity_io_oe_n    (parity_io_oe_n),
      .write_stall       (write_stall),
      .sleep_active      (sleep_active)
   );

   fbsc_far_model i_far (
      .sys_clk   (sys_clk),
      .ctl_drive (ctl_drive),
      .ctl_word  (ctl_word),
      .dev_oe_n  (data_io_oe_n),
      .dev_word  ({parity_io_o, data_io_o}),
      .pin_word  (pin_word),
      .clash     (clash)
   );

   // ------------------------------------------------------------
   // Expectation helpers and checks
   // ------------------------------------------------------------
   // Only the two low bits move; the upper bits stay at the loaded value
   function automatic logic [AW-1:0] beat_addr(logic [AW-1:0] s, logic [1:0] b, logic ilv);
      beat_addr = {s[AW-1:2], ilv ? (s[1:0] ^ b) : (s[1:0] + b)};
   endfunction

   // Selected lanes take data and their parity bit, the rest keep old contents
   function automatic logic [WW-1:0] merge(logic [WW-1:0] o, logic [WW-1:0] n,
         logic [1:0] ln_n);
      merge = o;
      for (int k = 0; k < 2; k++) begin
         if (!ln_n[k]) begin
            merge[8*k +: 8] = n[8*k +: 8];
            merge[16 + k]   = n[16 + k];
         end
      end
   endfunction

   function automatic logic [WW-1:0] rw();
      rw = WW'($random(seed));
   endfunction

   task automatic chk_bit(logic got, logic exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic chk_word(logic [WW-1:0] got, logic [WW-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One bus cycle: drive at the falling edge, model the rising edge, check after it.
   // Pending write data rides on whatever command follows, as the pins allow.
   task automatic step(int op, logic [AW-1:0] a, logic [1:0] ln, logic oe, logic [WW-1:0] wd);
      logic       ld;
      logic [2:0] cs;
      ld = (op == OP_RD || op == OP_WR || op == OP_SLP);
      cs = ld ? 3'h2 : 3'($random(seed));
      if (op == OP_DES) cs[2] = 1'b1;
      @(negedge sys_clk);
      clock_qualify_n   = (op == OP_HOLD);
      advance_or_load   = (op == OP_ADV) || (op == OP_HOLD && 1'($random(seed)));
      {chip_select_1_n, chip_select_2, chip_select_3_n} = cs;
      write_strobe_n    = (op == OP_WR) ? 1'b0 : (ld ? 1'b1 : 1'($random(seed)));
      address           = ld ? a : AW'($random(seed));
      byte_lane_write_n = ln;
      output_enable_n   = oe;
      burst_order       = ord;
      ctl_drive         = pend;
      ctl_word          = wd;
      #1;
      chk_bit(clash, 1'b0);
      @(posedge sys_clk);
      // Write data leaves the pins with the edge that takes it, before a read drives
      ctl_drive <= 1'b0;
      if (op != OP_HOLD && op != OP_SLP) begin
         if (pend) mem[p_addr] = merge(mem.exists(p_addr) ? mem[p_addr] : 'x, wd, p_lanes);
         if (ld) begin
            {b_act, b_wr, b_start, b_beat, b_ilv} = {1'b1, op == OP_WR, a, 2'h0, ord};
         end else if (op == OP_ADV) begin
            b_beat = b_beat + 2'h1;
         end else begin
            b_act = 1'b0;
         end
         cur     = beat_addr(b_start, b_beat, b_ilv);
         exp_oe  = !(b_act && !b_wr && !oe);
         pend    = b_act && b_wr;
         p_addr  = cur;
         p_lanes = ln;
         if (!exp_oe) exp_word = mem[cur];
      end else if (op == OP_SLP) begin
         exp_oe = 1'b1;
      end
      #1;
      chk_bit(data_io_oe_n, exp_oe);
      chk_bit(parity_io_oe_n, exp_oe);
      chk_bit(write_stall, 1'b0);
      if (!exp_oe) chk_word({parity_io_o, data_io_o}, exp_word);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      {clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n} = 4'h9;
      {write_strobe_n, advance_or_load, output_enable_n, sleep_request} = 4'ha;
      {burst_order, ctl_drive, byte_lane_write_n} = 4'h3;
      {b_act, b_wr, b_ilv, pend, exp_oe, ord} = 6'h08;
      address  = 18'h0_0000;
      ctl_word = 18'h0_0000;
      b_beat   = 2'h0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_bit(data_io_oe_n, 1'b1);
      chk_bit(sleep_active, 1'b0);
      rst_n = 1'b1;
      step(OP_DES, 18'h0_0000, 2'h3, 1'b0, rw());
      // Full write bursts then read-back with wrap, both orders, every start
      for (int o = 0; o < 2; o++) begin
         for (int s = 0; s < 4; s++) begin
            ord   = 1'(o);
            gbase = AW'($random(seed));
            gbase[1:0] = 2'(s);
            step(OP_WR, gbase, 2'h0, 1'b0, rw());
            repeat (3) step(OP_ADV, gbase, 2'h0, 1'b0, rw());
            step(OP_RD, gbase, 2'h0, 1'b0, rw());
            repeat (4) step(OP_ADV, gbase, 2'h0, 1'b0, rw());
            step(OP_DES, gbase, 2'h3, 1'b0, rw());
         end
      end
      // Every lane code back to back, the last one an abort, then a forwarded read
      for (int l = 0; l < 4; l++) step(OP_WR, gbase, 2'(l), 1'b1, rw());
      step(OP_RD, gbase, 2'h3, 1'b0, rw());
      // Ignored edges mid-burst, a dummy read and a deselect
      repeat (2) step(OP_HOLD, gbase, 2'h0, 1'b0, rw());
      step(OP_ADV, gbase, 2'h0, 1'b0, rw());
      step(OP_RD, gbase, 2'h0, 1'b1, rw());
      step(OP_DES, gbase, 2'h3, 1'b0, rw());
      // Random traffic kept inside the last fully written group
      repeat (60) begin
         op = {$random(seed)} % 5;
         if (op == OP_ADV && !b_act) op = OP_RD;
         ord = 1'($random(seed));
         step(op, {gbase[AW-1:2], 2'($random(seed))}, 2'($random(seed)), op == OP_WR,
            rw());
      end
      // Sleep only while deselected; commands in sleep are ignored
      repeat (2) step(OP_DES, gbase, 2'h3, 1'b1, rw());
      @(negedge sys_clk);
      sleep_request = 1'b1;
      @(posedge sys_clk);
      #1;
      chk_bit(sleep_active, 1'b0);
      step(OP_DES, gbase, 2'h3, 1'b1, rw());
      chk_bit(sleep_active, 1'b1);
      repeat (2) step(OP_SLP, gbase, 2'h0, 1'b0, rw());
      step(OP_DES, gbase, 2'h3, 1'b1, rw());
      @(negedge sys_clk);
      sleep_request = 1'b0;
      @(posedge sys_clk);
      #1;
      chk_bit(sleep_active, 1'b1);
      step(OP_DES, gbase, 2'h3, 1'b1, rw());
      chk_bit(sleep_active, 1'b0);
      repeat (2) step(OP_DES, gbase, 2'h3, 1'b1, rw());
      step(OP_RD, gbase, 2'h0, 1'b0, rw());
      repeat (3) step(OP_ADV, gbase, 2'h0, 1'b0, rw());
      step(OP_DES, gbase, 2'h3, 1'b0, rw());
      results();
   end

   // Whole run is under two hundred cycles; this limit only catches a hang
   initial begin
      #100us;
      error_cnt++;
      results();
   end
endmodule // fbsc_ctrl_tb
